// File: hdl/lbs_blink_timer.sv
`timescale 1ns/10ps
`default_nettype none

module lbs_blink_timer
    import lbs_pkg::*;
(
    input  wire logic    hclk,
    input  wire logic    hresetn,
    lbs_timing_if.timer  tim
);
    logic [11:0] pre_reg;
    logic [1:0]  frame_reg;
    logic [11:0] blink_reg;

    // Base tick: hclk divided by 16 * 2^div
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= 12'h000;
        end else if (pre_reg >= base_limit(tim.base_div)) begin
            pre_reg <= 12'h000;
        end else begin
            pre_reg <= pre_reg + 12'h001;
        end
    end

    assign tim.base_tick = (pre_reg >= base_limit(tim.base_div));

    // Frame position; a frame spans four base ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_reg <= 2'h0;
        end else if (tim.base_tick) begin
            frame_reg <= frame_reg + 2'h1;
        end
    end

    assign tim.frame_start = tim.base_tick && (frame_reg == FRAME_TICKS_M1);

    // Half blink period counter; >= catches a rate lowered mid-count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_reg <= 12'h000;
        end else if (tim.blink_half) begin
            blink_reg <= 12'h000;
        end else if (tim.base_tick) begin
            blink_reg <= blink_reg + 12'h001;
        end
    end

    assign tim.blink_half = tim.base_tick &&
                            (blink_reg >= blink_half_limit(tim.blink_rate));

endmodule

`default_nettype wire

// File: hdl/lbs_lcd_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module lbs_lcd_ctrl
    import lbs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] segment_drive,
    output logic             driver_enable,
    output logic             bias_gen_enable,
    output logic             divider_enable,
    output logic             ext_supply_switch,
    output logic             buffer_enable,
    output logic             internal_supply,
    output logic             lcd_operational
);
    lbs_timing_if tim ();

    logic [4:0]  blink_ctrl_reg;
    logic [4:0]  supply_ctrl_reg;
    logic [4:0]  panel_ctrl_reg;
    logic [7:0]  seg_on_reg    [SEG_MEM_WORDS];
    logic [7:0]  seg_blink_reg [SEG_MEM_WORDS];
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] rdata_reg;
    logic        blink_active_reg;
    logic        blink_off_reg;
    logic [4:0]  blank_cnt_reg;
    logic        pump_en_prev_reg;
    logic [31:0] seg_out_reg;
    logic        drv_en_reg;

    logic        addr_phase;
    logic [31:0] rdata_next;
    logic        pump_on;
    logic        pump_mode;
    logic        bypass;
    logic [1:0]  supply_src;
    logic        panel_en;
    logic        bank_sel;
    logic        blanking;
    logic        operational;
    logic [31:0] on_bits;
    logic [31:0] blink_bits;
    logic [31:0] seg_next;

    // Segment memory word index from a byte address, or -1 if outside the window
    function automatic int seg_index(input logic [7:0] addr);
        seg_index = -1;
        if (addr >= SEG_MEM_ADDR && addr < SEG_MEM_ADDR + 8'(4 * SEG_MEM_WORDS) &&
            addr[1:0] == 2'b00) begin
            seg_index = int'(addr - SEG_MEM_ADDR) / 4;
        end
    endfunction

    // Field views of the control registers
    assign pump_on    = supply_ctrl_reg[PUMP_EN_BIT];
    assign pump_mode  = supply_ctrl_reg[PUMP_MODE_BIT];
    assign bypass     = supply_ctrl_reg[BUF_BYPASS_BIT];
    assign supply_src = supply_ctrl_reg[SUPPLY_SRC_LSB +: 2];
    assign panel_en   = panel_ctrl_reg[PANEL_EN_BIT];
    assign bank_sel   = panel_ctrl_reg[BANK_SEL_BIT];

    // Timer hookup
    assign tim.base_div   = panel_ctrl_reg[BASE_DIV_LSB +: 3];
    assign tim.blink_rate = blink_ctrl_reg[BLINK_RATE_LSB +: 3];

    lbs_blink_timer u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tim     (tim)
    );

    // Zero-wait slave, always OKAY
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_reg;
    assign addr_phase = hsel && hready && htrans[1];

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= addr_phase && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Control register writes; unmapped addresses are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_ctrl_reg  <= BLINK_CTRL_RST;
            supply_ctrl_reg <= SUPPLY_CTRL_RST;
            panel_ctrl_reg  <= PANEL_CTRL_RST;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == BLINK_CTRL_ADDR) begin
                blink_ctrl_reg <= hwdata[4:0];
            end else if (wr_addr_reg == SUPPLY_CTRL_ADDR) begin
                supply_ctrl_reg <= hwdata[4:0];
            end else if (wr_addr_reg == PANEL_CTRL_ADDR) begin
                panel_ctrl_reg <= hwdata[4:0];
            end
        end
    end

    // Segment memory: bank select picks which bank the window reaches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < SEG_MEM_WORDS; i++) begin
                seg_on_reg[i]    <= 8'h00;
                seg_blink_reg[i] <= 8'h00;
            end
        end else if (wr_pend_reg && seg_index(wr_addr_reg) >= 0) begin
            if (bank_sel) begin
                seg_blink_reg[seg_index(wr_addr_reg)] <= hwdata[7:0];
            end else begin
                seg_on_reg[seg_index(wr_addr_reg)] <= hwdata[7:0];
            end
        end
    end

    // Read mux, evaluated in the address phase
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (haddr[7:0] == BLINK_CTRL_ADDR) begin
            rdata_next[4:0] = blink_ctrl_reg;
        end else if (haddr[7:0] == SUPPLY_CTRL_ADDR) begin
            rdata_next[4:0] = supply_ctrl_reg;
        end else if (haddr[7:0] == PANEL_CTRL_ADDR) begin
            rdata_next[4:0] = panel_ctrl_reg;
        end else if (haddr[7:0] == STATUS_ADDR) begin
            rdata_next[0] = blink_active_reg;
            rdata_next[1] = blink_off_reg;
            rdata_next[2] = blanking;
            rdata_next[3] = operational;
            rdata_next[4] = (supply_src == SUPPLY_EXT_ALL) && pump_on;
            rdata_next[5] = drv_en_reg;
        end else if (seg_index(haddr[7:0]) >= 0) begin
            rdata_next[7:0] = bank_sel ? seg_blink_reg[seg_index(haddr[7:0])]
                                       : seg_on_reg[seg_index(haddr[7:0])];
        end
    end

    // Read data register, loaded only for a read in its address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            rdata_reg <= rdata_next;
        end
    end

    // Blink on/off only follows software at frame start, so no torn frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_active_reg <= 1'b0;
        end else if (tim.frame_start) begin
            blink_active_reg <= blink_ctrl_reg[BLINK_ON_BIT];
        end
    end

    // Blink phase; each new blink run starts in the shown half
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_off_reg <= 1'b0;
        end else if (!blink_active_reg) begin
            blink_off_reg <= 1'b0;
        end else if (tim.blink_half) begin
            blink_off_reg <= !blink_off_reg;
        end
    end

    // Flatten segment banks; byte i carries frontplanes 2i and 2i+1
    always_comb begin
        for (int i = 0; i < SEG_MEM_WORDS; i++) begin
            on_bits[8*i +: 8]    = seg_on_reg[i];
            blink_bits[8*i +: 8] = seg_blink_reg[i];
        end
    end

    // Segments that blink go dark during the off half
    always_comb begin
        if (blink_active_reg && blink_off_reg) begin
            if (blink_ctrl_reg[BLINK_ALL_BIT]) begin
                seg_next = 32'h0000_0000;
            end else begin
                seg_next = on_bits & ~blink_bits;
            end
        end else begin
            seg_next = on_bits;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seg_out_reg <= 32'h0000_0000;
        end else begin
            seg_out_reg <= seg_next;
        end
    end

    // Blanking interval after pump enable rises, counted in base ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pump_en_prev_reg <= 1'b0;
            blank_cnt_reg    <= 5'h00;
        end else begin
            pump_en_prev_reg <= pump_on;
            if (pump_on && !pump_en_prev_reg) begin
                blank_cnt_reg <= PUMP_BLANK_TICKS;
            end else if (tim.base_tick && blank_cnt_reg != 5'h00) begin
                blank_cnt_reg <= blank_cnt_reg - 5'h01;
            end
        end
    end

    assign blanking = (blank_cnt_reg != 5'h00) || (pump_on && !pump_en_prev_reg);

    // Operational state of the supply configuration
    always_comb begin
        case (supply_src)
            SUPPLY_VDD_LL2: operational = pump_on;
            SUPPLY_VDD_LL3: operational = pump_on;
            SUPPLY_EXT_LCD: operational = pump_on;
            default:        operational = !pump_on;
        endcase
    end

    // Panel drivers; a disabled supply keeps the glass undriven
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drv_en_reg <= 1'b0;
        end else begin
            drv_en_reg <= panel_en && !blanking && operational;
        end
    end

    // Supply switch controls straight from register bits
    assign bias_gen_enable   = pump_on;
    assign divider_enable    = !pump_mode;
    assign ext_supply_switch = (supply_src == SUPPLY_EXT_LCD);
    assign internal_supply   = !supply_src[1];
    assign buffer_enable     = !bypass && ext_supply_switch;
    assign lcd_operational   = operational;
    assign segment_drive     = seg_out_reg;
    assign driver_enable     = drv_en_reg;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    blink_frame_sync_a: assert property (
        $changed(blink_active_reg) |-> $past(tim.frame_start))
        else $error("blink state changed off a frame start");

    blink_follow_a: assert property (
        tim.frame_start |=> blink_active_reg == $past(blink_ctrl_reg[BLINK_ON_BIT]))
        else $error("blink state did not follow control bit");

    blank_hold_a: assert property (
        (pump_on && !pump_en_prev_reg) |=> (blank_cnt_reg == 5'h10) && !drv_en_reg)
        else $error("pump enable did not start blanking");

    blank_drv_a: assert property (
        blanking |=> !drv_en_reg)
        else $error("drivers enabled during pump blanking");

    blink_all_a: assert property (
        (blink_active_reg && blink_off_reg && blink_ctrl_reg[BLINK_ALL_BIT])
        |=> segment_drive == 32'h0000_0000)
        else $error("blink-all left a segment lit");

    blink_segment_a: assert property (
        (blink_active_reg && blink_off_reg && !blink_ctrl_reg[BLINK_ALL_BIT])
        |=> segment_drive == $past(on_bits & ~blink_bits))
        else $error("per-segment blink wrong");

    blink_idle_a: assert property (
        !blink_active_reg |=> segment_drive == $past(on_bits))
        else $error("segments changed while not blinking");

    blink_toggle_a: assert property (
        (blink_active_reg && tim.blink_half) ##1 blink_active_reg
        |-> blink_off_reg != $past(blink_off_reg))
        else $error("blink phase missed half period");

    ext_off_a: assert property (
        (supply_src == SUPPLY_EXT_LCD && !pump_on) |=> !drv_en_reg)
        else $error("external supply without pump drove panel");

    buffer_ctrl_a: assert property (
        (bypass || supply_src != SUPPLY_EXT_LCD) |-> !buffer_enable)
        else $error("supply buffer enabled while bypassed");

    blink_start_a: assert property (
        $rose(blink_active_reg) |-> !blink_off_reg)
        else $error("blink run started in the dark half");

    drv_gate_a: assert property (
        driver_enable |-> $past(panel_en && !blanking && operational))
        else $error("drivers on without enable, supply or end of blanking");

    blank_count_a: assert property (
        (tim.base_tick && blank_cnt_reg != 5'h00 && !(pump_on && !pump_en_prev_reg))
        |=> blank_cnt_reg == $past(blank_cnt_reg) - 5'h01)
        else $error("blanking count skipped a base tick");

    tick_gap_a: assert property (
        tim.base_tick |=> !tim.base_tick)
        else $error("base tick lasted two cycles");

    ext_all_a: assert property (
        (supply_src == SUPPLY_EXT_ALL)
        |-> !internal_supply && !ext_supply_switch && !buffer_enable)
        else $error("fully external supply left a switch or the buffer on");

endmodule

`default_nettype wire

// File: hdl/lbs_pkg.sv
package lbs_pkg;

    // Register byte addresses on the AHB-Lite bus
    localparam logic [7:0] BLINK_CTRL_ADDR  = 8'h00;
    localparam logic [7:0] SUPPLY_CTRL_ADDR = 8'h04;
    localparam logic [7:0] PANEL_CTRL_ADDR  = 8'h08;
    localparam logic [7:0] STATUS_ADDR      = 8'h0C;
    localparam logic [7:0] SEG_MEM_ADDR     = 8'h40;
    localparam int         SEG_MEM_WORDS    = 4;

    // blink_control_reg fields
    localparam int BLINK_ON_BIT   = 0;
    localparam int BLINK_ALL_BIT  = 1;
    localparam int BLINK_RATE_LSB = 2;

    // supply_control_reg fields
    localparam int PUMP_EN_BIT     = 0;
    localparam int PUMP_MODE_BIT   = 1;
    localparam int BUF_BYPASS_BIT  = 2;
    localparam int SUPPLY_SRC_LSB  = 3;

    // panel control fields
    localparam int PANEL_EN_BIT    = 0;
    localparam int BANK_SEL_BIT    = 1;
    localparam int BASE_DIV_LSB    = 2;

    // Reset values
    localparam logic [4:0] BLINK_CTRL_RST  = 5'h00;
    localparam logic [4:0] SUPPLY_CTRL_RST = 5'h00;
    localparam logic [4:0] PANEL_CTRL_RST  = 5'h00;

    // Timing counts, in waveform base clock ticks; BASE_DIV_MIN is in hclk cycles
    localparam logic [1:0] FRAME_TICKS_M1  = 2'h3;
    localparam logic [4:0] PUMP_BLANK_TICKS = 5'h10;
    localparam int         BLINK_EXP_BASE  = 5;
    localparam int         BASE_DIV_MIN    = 16;

    // Supply source codes
    localparam logic [1:0] SUPPLY_VDD_LL2 = 2'b00;
    localparam logic [1:0] SUPPLY_VDD_LL3 = 2'b01;
    localparam logic [1:0] SUPPLY_EXT_LCD = 2'b10;
    localparam logic [1:0] SUPPLY_EXT_ALL = 2'b11;

    // Reload value of the hclk prescaler for a base divider code
    function automatic logic [11:0] base_limit(input logic [2:0] div);
        base_limit = (12'(BASE_DIV_MIN) << div) - 12'h001;
    endfunction

    // Reload value for half a blink period, 2^(5+rate)/2 ticks
    function automatic logic [11:0] blink_half_limit(input logic [2:0] rate);
        blink_half_limit = (12'h001 << (BLINK_EXP_BASE - 1 + int'(rate))) - 12'h001;
    endfunction

endpackage

// File: hdl/lbs_timing_if.sv
`timescale 1ns/10ps
`default_nettype none

interface lbs_timing_if;
    logic [2:0] base_div;
    logic [2:0] blink_rate;
    logic       base_tick;
    logic       frame_start;
    logic       blink_half;

    modport ctrl  (output base_div, output blink_rate,
                   input base_tick, input frame_start, input blink_half);
    modport timer (input base_div, input blink_rate,
                   output base_tick, output frame_start, output blink_half);
endinterface

`default_nettype wire

// File: test/lbs_glass_model.sv
`timescale 1ns/10ps
`default_nettype none

module lbs_glass_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [31:0] segment_drive,
    input  wire logic        driver_enable,
    output logic      [31:0] lit,
    output logic      [31:0] span,
    output logic      [15:0] flips
);
    logic [31:0] seen_q;
    logic [31:0] cnt;

    // Passive glass: nothing shows while the drivers are off
    assign lit = driver_enable ? segment_drive : 32'h0000_0000;

    // Cycles between pattern changes, so the bench can judge the blink rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 32'h0000_0000;
            cnt    <= 32'h0000_0001;
            span   <= 32'h0000_0000;
            flips  <= 16'h0000;
        end else if (segment_drive != seen_q) begin
            seen_q <= segment_drive;
            span   <= cnt;
            cnt    <= 32'h0000_0001;
            flips  <= flips + 16'h0001;
        end else begin
            cnt    <= cnt + 32'h0000_0001;
        end
    end
endmodule

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import lbs_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] segment_drive;
    logic        driver_enable;
    logic        bias_gen_enable;
    logic        divider_enable;
    logic        ext_supply_switch;
    logic        buffer_enable;
    logic        internal_supply;
    logic        lcd_operational;
    logic [31:0] lit;
    logic [31:0] span;
    logic [15:0] flips;
    logic [31:0] rd;
    logic [4:0]  s;
    int          n_mismatch;
    int          checks;
    localparam logic [31:0] PAT = 32'hC35A_96A5;
    localparam logic [31:0] BLK = 32'h0FF0_3C81;

    lbs_lcd_ctrl i_lbs_lcd_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .segment_drive(segment_drive), .driver_enable(driver_enable),
        .bias_gen_enable(bias_gen_enable), .divider_enable(divider_enable),
        .ext_supply_switch(ext_supply_switch), .buffer_enable(buffer_enable),
        .internal_supply(internal_supply), .lcd_operational(lcd_operational)
    );

    lbs_glass_model i_lbs_glass_model (
        .hclk(hclk), .hresetn(hresetn), .segment_drive(segment_drive),
        .driver_enable(driver_enable), .lit(lit), .span(span), .flips(flips)
    );

    // 100 ns clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // One single AHB-Lite word transfer; waits on hready, no fixed latency
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask

    // Start a blink, check the dark half and its length, then stop it
    task automatic blink_run(input logic [2:0] dv, input logic [2:0] rt,
                             input logic all, input logic [31:0] dark);
        int f;
        wr(PANEL_CTRL_ADDR, {27'h000_0000, dv, 2'b01});
        wr(BLINK_CTRL_ADDR, {27'h000_0000, rt, all, 1'b1});
        f = int'(flips);
        while (int'(flips) < f + 1) @(posedge hclk);
        chk(segment_drive, dark);
        while (int'(flips) < f + 2) @(posedge hclk);
        chk(span, 32'h0000_0100 << (4'(dv) + 4'(rt)));
        wr(BLINK_CTRL_ADDR, {27'h000_0000, rt, all, 1'b0});
        cyc(80 << dv);
        chk(segment_drive, PAT);
        f = int'(flips);
        cyc(300);
        chk(32'(flips), 32'(f));
        $display("test blink div %0d rate %0d done", dv, rt);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard; the slowest blink run needs about 66k cycles, all tests about 70k
    initial begin
        #(90000 * 100);
        n_mismatch++;
        $display("watchdog expired at %0t", $time);
        give_verdict();
    end

    initial begin
        n_mismatch = 0;
        checks     = 0;
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0000_0000;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = 3'b010;
        hwdata     = 32'h0000_0000;
        cyc(5);
        hresetn <= 1'b1;
        // Idle state, register reset values and an unmapped place
        chk(32'({hreadyout, hresp, divider_enable, bias_gen_enable}), 32'h0000_000A);
        for (int i = 0; i < 3; i++) rdc(8'(4 * i), 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rdc(8'h20, 32'h0000_0000);
        $display("test reset done");
        // Every supply setting except pump on with code 11
        for (int v = 0; v < 32; v++) begin
            s = 5'(v);
            if (s[4:3] == 2'b11 && s[0]) continue;
            wr(SUPPLY_CTRL_ADDR, 32'(s));
            cyc(2);
            chk(32'({bias_gen_enable, divider_enable, ext_supply_switch, internal_supply,
                     buffer_enable, lcd_operational}),
                32'({s[0], !s[1], s[4:3] == 2'b10, !s[4], !s[2] && s[4:3] == 2'b10,
                     s[0] ? s[4:3] != 2'b11 : s[4:3] == 2'b11}));
            rdc(SUPPLY_CTRL_ADDR, 32'(s));
        end
        $display("test supply done");
        // Both memory banks, upper data bits dropped
        for (int b = 0; b < 2; b++) begin
            wr(PANEL_CTRL_ADDR, 32'(2 * b + 1));
            for (int i = 0; i < 4; i++)
                wr(SEG_MEM_ADDR + 8'(4 * i), {24'hFF_FFFF, (b ? BLK[8*i+:8] : PAT[8*i+:8])});
        end
        for (int b = 1; b >= 0; b--) begin
            wr(PANEL_CTRL_ADDR, 32'(2 * b + 1));
            for (int i = 0; i < 4; i++)
                rdc(SEG_MEM_ADDR + 8'(4 * i), {24'h00_0000, (b ? BLK[8*i+:8] : PAT[8*i+:8])});
        end
        cyc(2);
        chk(segment_drive, PAT);
        $display("test memory done");
        // Output blanking after the pump comes on
        wr(SUPPLY_CTRL_ADDR, 32'h0000_0010);
        cyc(4);
        chk(32'(driver_enable), 32'h0000_0000);
        wr(SUPPLY_CTRL_ADDR, 32'h0000_0011);
        cyc(220);
        chk(32'(driver_enable), 32'h0000_0000);
        rdc(STATUS_ADDR, 32'h0000_000C);
        cyc(60);
        chk(32'(driver_enable), 32'h0000_0001);
        chk(lit, PAT);
        rdc(STATUS_ADDR, 32'h0000_0028);
        $display("test blanking done");
        blink_run(3'd0, 3'd0, 1'b1, 32'h0000_0000);
        blink_run(3'd1, 3'd0, 1'b0, PAT & ~BLK);
        blink_run(3'd0, 3'd7, 1'b1, 32'h0000_0000);
        // Reset in mid-run brings registers and outputs back to idle
        hresetn <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        chk(segment_drive, 32'h0000_0000);
        chk(32'({driver_enable, bias_gen_enable, divider_enable, lcd_operational}),
            32'h0000_0002);
        rdc(BLINK_CTRL_ADDR, 32'h0000_0000);
        rdc(SEG_MEM_ADDR, 32'h0000_0000);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule

`default_nettype wire
